// ---- inc/status_pkg.sv ----
// constants for the module status and command response block
package status_pkg;
  localparam logic [7:0]  STATUS_ADDR      = 8'h00;
  localparam logic [7:0]  GENERAL_CONFIG_REGISTER_ADDR      = 8'h08;
  localparam int          PEND_LSB         = 8;
  localparam int          PEND_W           = 8;
  localparam int          READY_BIT        = 4;
  localparam int          ERR_W            = 4;
  localparam int          RSTAT_LSB        = 24;
  localparam logic [15:0] STATUS_RESET     = 16'h0000;
  localparam logic [7:0]  PEND_NONE        = 8'h00;
  localparam logic [2:0]  RSVD_VALUE       = 3'h0;
  localparam logic [3:0]  ERR_OK           = 4'h0;
  localparam logic [3:0]  ERR_UNIMPL       = 4'h1;
  localparam logic [3:0]  ERR_READ_ONLY    = 4'h2;
  localparam logic [3:0]  ERR_PENDING      = 4'h4;
  localparam logic [3:0]  ERR_INIT         = 4'h5;
  localparam logic [3:0]  ERR_GENERAL      = 4'h8;
  localparam logic [3:0]  ERR_VENDOR       = 4'hF;
  localparam logic [1:0]  RSP_OK           = 2'h0;
  localparam logic [1:0]  RSP_XE           = 2'h1;
  localparam logic [1:0]  RSP_PEND         = 2'h3;
  localparam logic [15:0] SAVE_DEFAULT_BIT = 16'h0001;
  localparam int          CLK_MHZ          = 250;
  localparam int          EXEC_MAX_US      = 5000;
  localparam int          EXEC_CYCLES      = EXEC_MAX_US * CLK_MHZ - 1;
  localparam int          RESP_CYCLES      = 4;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_RESP = 2'b11
  } cmd_state_e;
endpackage

// ---- logic/nv_defaults.sv ----
// non-volatile default store with load at reset and save on request
`timescale 1ns/10ps
module nv_defaults #(
  parameter int DEPTH = 4
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        save,
  input  wire logic [15:0] live_value [DEPTH],
  output logic      [15:0] default_value [DEPTH],
  output logic             loaded
);
  logic [15:0] store_reg [DEPTH];
  logic [15:0] store_next [DEPTH];
  logic        loaded_reg;
  logic        loaded_next;

  // store itself is not reset: it models memory that survives reset
  always_comb begin
    loaded_next = 1'b1;
    for (int i = 0; i < DEPTH; i++) begin
      store_next[i] = save ? live_value[i] : store_reg[i];
    end
  end

  always_ff @(posedge clk) begin
    for (int i = 0; i < DEPTH; i++) begin
      store_reg[i] <= store_next[i];
    end
    if (!resetn) begin
      loaded_reg <= 1'b0;
    end else begin
      loaded_reg <= loaded_next;
    end
  end

  assign default_value = store_reg;
  assign loaded        = loaded_reg;
endmodule

// ---- logic/module_status_register.sv ----
// status register, command execution timing and response generation
`timescale 1ns/10ps
module module_status_register #(
  parameter int EXEC_CYCLES = status_pkg::EXEC_CYCLES,
  parameter int NV_DEPTH    = 4
) (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        cmd_valid,
  input  wire logic        cmd_write,
  input  wire logic [7:0]  cmd_addr,
  input  wire logic [15:0] cmd_data,
  input  wire logic        cmd_pendable,
  input  wire logic        reg_implemented,
  input  wire logic        reg_writable,
  input  wire logic        exec_done,
  input  wire logic        exec_fail,
  input  wire logic        ready_in,
  output logic             cmd_ack,
  output logic             rsp_valid,
  output logic      [25:0] rsp_word,
  output logic      [15:0] module_status,
  output logic             module_ready,
  output logic      [15:0] nv_default0
);
  localparam int CW = $clog2(EXEC_CYCLES + 1);

  status_pkg::cmd_state_e state_reg, state_next;
  logic [CW-1:0] cnt_reg, cnt_next;
  logic [7:0]    pend_reg, pend_next;
  logic [2:0]    slot_reg, slot_next;
  logic [3:0]    err_reg, err_next;
  logic          rdy_reg, rdy_next;
  logic          ack_reg, ack_next;
  logic          rv_reg, rv_next;
  logic [25:0]   rw_reg, rw_next;
  logic [15:0]   stat_reg, stat_next;
  logic          wr_reg, wr_next;
  logic          pendable_reg, pendable_next;
  logic          save;
  logic [15:0]   live [NV_DEPTH];
  logic [15:0]   dflt [NV_DEPTH];
  logic          nv_loaded;
  logic [15:0]   nv0_reg, nv0_next;
  logic [15:0]   status_view;
  logic          pend_expire;

  generate
    for (genvar g = 0; g < NV_DEPTH; g++) begin : g_live
      assign live[g] = (g == 0) ? cmd_data : dflt[g];
    end
  endgenerate

  assign save = cmd_valid && ack_next && cmd_write &&
                cmd_addr == status_pkg::GENERAL_CONFIG_REGISTER_ADDR &&
                (cmd_data & status_pkg::SAVE_DEFAULT_BIT) != 16'h0000;

  // a pending operation that never reports done is retired at the limit
  assign pend_expire = state_reg == status_pkg::ST_IDLE &&
                       pend_reg != status_pkg::PEND_NONE && !exec_done &&
                       cnt_reg == CW'(EXEC_CYCLES);

  nv_defaults #(.DEPTH(NV_DEPTH)) u_nv (
    .clk          (clk),
    .resetn       (resetn),
    .save         (save),
    .live_value   (live),
    .default_value(dflt),
    .loaded       (nv_loaded)
  );

  // reserved bits forced to zero here, not stored
  assign status_view = {pend_reg, status_pkg::RSVD_VALUE, rdy_reg,
                        err_reg};

  always_comb begin
    state_next    = state_reg;
    cnt_next      = cnt_reg;
    pend_next     = pend_reg;
    slot_next     = slot_reg;
    err_next      = err_reg;
    ack_next      = 1'b0;
    rv_next       = 1'b0;
    rw_next       = rw_reg;
    wr_next       = wr_reg;
    pendable_next = pendable_reg;
    nv0_next      = nv_loaded ? nv0_reg : dflt[0];
    rdy_next      = ready_in && nv_loaded;
    // background completion of pending operations; the count keeps
    // running so a stuck pending operation still meets the limit
    if (state_reg == status_pkg::ST_IDLE &&
        pend_reg != status_pkg::PEND_NONE) begin
      cnt_next = cnt_reg + 1'b1;
      if (exec_done) begin
        pend_next = pend_reg & ~(8'h01 << slot_reg);
      end
    end
    case (state_reg)
      status_pkg::ST_IDLE: begin
        if (cmd_valid) begin
          ack_next = 1'b1;
          if (cmd_addr == status_pkg::STATUS_ADDR) begin
            // read reports last error, then clears it
            rv_next = 1'b1;
            // bits 23:16 of the response are unused by this block
            rw_next = {status_pkg::RSP_OK, 8'h00,
                       cmd_write ? cmd_data : status_view};
            err_next = status_pkg::ERR_OK;
          end else if (pend_reg != status_pkg::PEND_NONE) begin
            rv_next  = 1'b1;
            rw_next  = {status_pkg::RSP_XE, 24'h000000};
            err_next = status_pkg::ERR_PENDING;
          end else if (!nv_loaded) begin
            rv_next  = 1'b1;
            rw_next  = {status_pkg::RSP_XE, 24'h000000};
            err_next = status_pkg::ERR_INIT;
          end else if (!reg_implemented) begin
            rv_next  = 1'b1;
            rw_next  = {status_pkg::RSP_XE, 24'h000000};
            err_next = status_pkg::ERR_UNIMPL;
          end else if (cmd_write && !reg_writable) begin
            rv_next  = 1'b1;
            rw_next  = {status_pkg::RSP_XE, 24'h000000};
            err_next = status_pkg::ERR_READ_ONLY;
          end else begin
            state_next    = status_pkg::ST_EXEC;
            cnt_next      = '0;
            wr_next       = cmd_write;
            pendable_next = cmd_pendable;
            rw_next       = {status_pkg::RSP_OK, 8'h00, cmd_data};
          end
        end
      end
      status_pkg::ST_EXEC: begin
        cnt_next = cnt_reg + 1'b1;
        if (exec_done || exec_fail) begin
          rv_next    = 1'b1;
          state_next = status_pkg::ST_IDLE;
          err_next   = exec_fail ? status_pkg::ERR_GENERAL
                                 : status_pkg::ERR_OK;
          rw_next[25:24] = exec_fail ? status_pkg::RSP_XE
                                     : status_pkg::RSP_OK;
          if (exec_fail) begin
            rw_next[15:0] = 16'h0000;
          end
        end else if (pendable_reg &&
                     cnt_reg == CW'(status_pkg::RESP_CYCLES)) begin
          // early answer; execution continues in background
          rv_next        = 1'b1;
          rw_next[25:24] = status_pkg::RSP_PEND;
          pend_next      = pend_reg | (8'h01 << slot_reg);
          state_next     = status_pkg::ST_IDLE;
        end else if (!pendable_reg &&
                     cnt_reg == CW'(status_pkg::RESP_CYCLES)) begin
          state_next = status_pkg::ST_RESP;
        end
      end
      status_pkg::ST_RESP: begin
        // non-pendable command past its answer time: vendor error on fail or at the limit, ok on done
        cnt_next = cnt_reg + 1'b1;
        if (exec_done || exec_fail ||
            cnt_reg == CW'(EXEC_CYCLES)) begin
          rv_next    = 1'b1;
          rw_next    = {status_pkg::RSP_XE, 24'h000000};
          err_next   = exec_done && !exec_fail ? status_pkg::ERR_OK
                                               : status_pkg::ERR_VENDOR;
          if (exec_done && !exec_fail) begin
            rw_next[25:24] = status_pkg::RSP_OK;
          end
          state_next = status_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = status_pkg::ST_IDLE;
      end
    endcase
    // expiry wins over a status read clearing the error in one cycle
    if (pend_expire) begin
      pend_next = pend_reg & ~(8'h01 << slot_reg);
      err_next  = status_pkg::ERR_VENDOR;
    end
    stat_next = {pend_next, status_pkg::RSVD_VALUE, rdy_next, err_next};
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg    <= status_pkg::ST_IDLE;
      cnt_reg      <= '0;
      pend_reg     <= status_pkg::PEND_NONE;
      slot_reg     <= 3'h0;
      err_reg      <= status_pkg::ERR_OK;
      rdy_reg      <= 1'b0;
      ack_reg      <= 1'b0;
      rv_reg       <= 1'b0;
      rw_reg       <= '0;
      stat_reg     <= status_pkg::STATUS_RESET;
      wr_reg       <= 1'b0;
      pendable_reg <= 1'b0;
      nv0_reg      <= 16'h0000;
    end else begin
      state_reg    <= state_next;
      cnt_reg      <= cnt_next;
      pend_reg     <= pend_next;
      slot_reg     <= slot_next;
      err_reg      <= err_next;
      rdy_reg      <= rdy_next;
      ack_reg      <= ack_next;
      rv_reg       <= rv_next;
      rw_reg       <= rw_next;
      stat_reg     <= stat_next;
      wr_reg       <= wr_next;
      pendable_reg <= pendable_next;
      nv0_reg      <= nv0_next;
    end
  end

  assign cmd_ack       = ack_reg;
  assign rsp_valid     = rv_reg;
  assign rsp_word      = rw_reg;
  assign module_status = stat_reg;
  assign module_ready  = rdy_reg;
  assign nv_default0   = nv0_reg;

  sequence s_status_cmd;
    state_reg == status_pkg::ST_IDLE && cmd_valid &&
    cmd_addr == status_pkg::STATUS_ADDR;
  endsequence

  AST_RESET_ZERO: assert property (@(posedge clk)
    !resetn |=> module_status == 16'h0000)
    else $error("status not zero after reset");
  AST_RSVD_ZERO: assert property (@(posedge clk)
    disable iff (!resetn) module_status[7:5] == 3'h0)
    else $error("reserved status bits nonzero");
  AST_STATUS_OK: assert property (@(posedge clk)
    disable iff (!resetn) s_status_cmd |=> rsp_valid &&
    rsp_word[25:24] == status_pkg::RSP_OK)
    else $error("status command not answered ok");
  AST_STATUS_READ: assert property (@(posedge clk)
    disable iff (!resetn) (s_status_cmd and !cmd_write) |=>
    rsp_word[15:0] == $past(status_view))
    else $error("status read data wrong");
  AST_WRITE_ECHO: assert property (@(posedge clk)
    disable iff (!resetn) (s_status_cmd and cmd_write) |=>
    rsp_word[15:0] == $past(cmd_data) && err_reg == 4'h0)
    else $error("status write mishandled");
  AST_ERR_CLEAR: assert property (@(posedge clk)
    disable iff (!resetn) (s_status_cmd and !pend_expire) |=>
    err_reg == 4'h0)
    else $error("error field not cleared by status read");
  AST_RSP_BOUND: assert property (@(posedge clk)
    disable iff (!resetn) state_reg == status_pkg::ST_EXEC &&
    pendable_reg |-> ##[0:6] rsp_valid)
    else $error("pendable response late");
  AST_READY: assert property (@(posedge clk)
    disable iff (!resetn) module_ready |-> $past(ready_in))
    else $error("ready without cause");
  AST_NO_PEND_NP: assert property (@(posedge clk)
    disable iff (!resetn) rsp_valid && rsp_word[25:24] ==
    status_pkg::RSP_PEND |-> $past(pendable_reg))
    else $error("non-pendable command went pending");
endmodule

// ---- verif/host_model.sv ----
// host controller model issuing register commands one at a time
`timescale 1ns/10ps
module host_model #(
  parameter int LIMIT = 60
) (
  input  wire logic        clk,
  input  wire logic        cmd_ack,
  input  wire logic        rsp_valid,
  input  wire logic [25:0] rsp_word,
  output logic             cmd_valid,
  output logic             cmd_write,
  output logic      [7:0]  cmd_addr,
  output logic      [15:0] cmd_data,
  output logic             cmd_pendable,
  output logic             reg_implemented,
  output logic             reg_writable
);
  initial begin
    {cmd_valid, cmd_write, cmd_pendable} = 3'h0;
    {reg_implemented, reg_writable} = 2'h0;
    cmd_addr = 8'h00;
    cmd_data = 16'h0000;
  end
  // next command only after the answer, so polls see settled state
  task automatic issue(input logic w, input logic [7:0] a,
                       input logic [15:0] d, input logic [2:0] f,
                       output logic [25:0] rsp, output int lat);
    int n;
    cmd_write <= w;
    cmd_addr <= a;
    cmd_data <= d;
    {cmd_pendable, reg_implemented, reg_writable} <= f;
    cmd_valid <= 1'b1;
    @(posedge clk);
    // released address and data lines show the inverse, never a stale copy
    cmd_valid <= 1'b0;
    cmd_addr <= ~a;
    cmd_data <= ~d;
    n = 0;
    while (cmd_ack !== 1'b1 && n < 8) begin
      @(posedge clk);
      n++;
    end
    lat = 0;
    while (rsp_valid !== 1'b1 && lat < LIMIT) begin
      @(posedge clk);
      lat++;
    end
    rsp = rsp_word;
  endtask
endmodule

// ---- verif/module_status_register_test.sv ----
// self-checking bench for the status and response block
`timescale 1ns/10ps
module module_status_register_test;
  localparam int EXEC = 50;
  logic clk = 1'b0, resetn = 1'b0, exec_done = 1'b0;
  logic exec_fail = 1'b0, ready_in = 1'b0;
  logic cmd_valid, cmd_write, cmd_pendable, reg_implemented;
  logic reg_writable, cmd_ack, rsp_valid, module_ready;
  logic [7:0]  cmd_addr;
  logic [15:0] cmd_data, module_status, nv_default0;
  logic [25:0] rsp_word, rsp;
  int lat, n_errors = 0, checked = 0;
  always #2 clk = ~clk;
  host_model #(.LIMIT(EXEC + 10)) host (
    .clk(clk), .cmd_ack(cmd_ack), .rsp_valid(rsp_valid),
    .rsp_word(rsp_word), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
    .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_pendable(cmd_pendable), .reg_implemented(reg_implemented),
    .reg_writable(reg_writable));
  module_status_register #(.EXEC_CYCLES(EXEC)) uut (
    .clk(clk), .resetn(resetn), .cmd_valid(cmd_valid),
    .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_data(cmd_data),
    .cmd_pendable(cmd_pendable), .reg_implemented(reg_implemented),
    .reg_writable(reg_writable), .exec_done(exec_done),
    .exec_fail(exec_fail), .ready_in(ready_in), .cmd_ack(cmd_ack),
    .rsp_valid(rsp_valid), .rsp_word(rsp_word),
    .module_status(module_status), .module_ready(module_ready),
    .nv_default0(nv_default0));
  function automatic logic [25:0] pick(input logic [25:0] r);
    return {8'h00, r[25:24], r[15:0]};
  endfunction
  function automatic logic [25:0] resp(input logic [1:0] s,
                                       input logic [15:0] d);
    return {8'h00, s, d};
  endfunction
  task automatic chk(input logic [25:0] got, exp, input string what);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic chk_le(input int got, lim, input string what);
    checked++;
    if (got > lim) begin
      n_errors++;
      $display("BAD %0t %s took %0d", $time, what, got);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // exec pulse runs beside the command, as the far logic would
  task automatic op(input logic w, input logic [7:0] a,
                    input logic [15:0] d, input logic [2:0] f,
                    input int done_at, input logic fail);
    fork
      host.issue(w, a, d, f, rsp, lat);
      if (done_at > 0) begin
        repeat (done_at) @(posedge clk);
        exec_done <= ~fail;
        exec_fail <= fail;
        @(posedge clk);
        exec_done <= 1'b0;
        exec_fail <= 1'b0;
      end
    join
    chk_le(lat, EXEC + 6, "answer time");
  endtask
  task automatic rd_status(input logic [15:0] exp);
    op(1'b0, status_pkg::STATUS_ADDR, 16'h0000, 3'h3, 0, 1'b0);
    chk(pick(rsp), resp(status_pkg::RSP_OK, exp), "status read");
  endtask
  task automatic chk_code(input logic [1:0] exp);
    chk({24'h000000, rsp[25:24]}, {24'h000000, exp}, "rsp code");
  endtask
  task automatic do_reset;
    resetn <= 1'b0;
    repeat (10) @(posedge clk);
    chk({10'h000, module_status}, 26'h0, "reset status");
    chk({25'h0, module_ready}, 26'h0, "reset ready");
    resetn <= 1'b1;
  endtask
  task automatic t_basic;
    rd_status(16'h0000);
    chk_le(lat, 1, "status answer");
    op(1'b1, status_pkg::STATUS_ADDR, 16'hFFFF, 3'h3, 0, 1'b0);
    chk_code(status_pkg::RSP_OK);
    chk(pick(rsp), resp(status_pkg::RSP_OK, 16'hFFFF), "echo");
    @(posedge clk);
    chk({10'h000, module_status}, 26'h0, "not loaded");
    $display("test basic done");
  endtask
  task automatic t_errors;
    logic [3:0] code;
    for (int i = 0; i < 2; i++) begin
      code = i ? status_pkg::ERR_READ_ONLY : status_pkg::ERR_UNIMPL;
      op(i[0], 8'h10, 16'h1234, i ? 3'h2 : 3'h1, 0, 1'b0);
      chk(pick(rsp), resp(status_pkg::RSP_XE, 16'h0000), "xe");
      rd_status({12'h000, code});
      rd_status(16'h0000);
    end
    $display("test errors done");
  endtask
  task automatic t_exec;
    op(1'b1, 8'h10, 16'h1234, 3'h3, 4, 1'b0);
    chk_code(status_pkg::RSP_OK);
    op(1'b1, 8'h10, 16'h1234, 3'h3, 4, 1'b1);
    chk(pick(rsp), resp(status_pkg::RSP_XE, 16'h0000), "fail");
    rd_status({12'h000, status_pkg::ERR_GENERAL});
    op(1'b1, 8'h10, 16'h1234, 3'h3, 0, 1'b0);
    chk_code(status_pkg::RSP_XE);
    chk_le(lat, EXEC + 6, "exec bound");
    rd_status({12'h000, status_pkg::ERR_VENDOR});
    $display("test exec done");
  endtask
  task automatic t_pending;
    op(1'b1, 8'h10, 16'h00FF, 3'h7, 0, 1'b0);
    chk_code(status_pkg::RSP_PEND);
    chk_le(lat, 6, "pend answer");
    @(posedge clk);
    chk({10'h000, module_status}, 26'h100, "flag");
    rd_status(16'h0100);
    op(1'b0, 8'h10, 16'h0000, 3'h3, 0, 1'b0);
    chk(pick(rsp), resp(status_pkg::RSP_XE, 16'h0000), "busy");
    rd_status(16'h0104);
    exec_done <= 1'b1;
    @(posedge clk);
    exec_done <= 1'b0;
    repeat (2) @(posedge clk);
    chk({10'h000, module_status}, 26'h0, "flag clear");
    rd_status(16'h0000);
    // never reported done: retired at the execution limit
    op(1'b1, 8'h10, 16'h00FF, 3'h7, 0, 1'b0);
    chk_code(status_pkg::RSP_PEND);
    repeat (EXEC) @(posedge clk);
    chk({10'h000, module_status}, 26'h000F, "pend expire");
    rd_status(16'h000F);
    $display("test pending done");
  endtask
  task automatic t_ready;
    ready_in <= 1'b1;
    repeat (3) @(posedge clk);
    chk({25'h0, module_ready}, 26'h1, "ready");
    rd_status(16'h0010);
    ready_in <= 1'b0;
    repeat (3) @(posedge clk);
    chk({25'h0, module_ready}, 26'h0, "not ready");
    $display("test ready done");
  endtask
  task automatic t_nv;
    op(1'b1, status_pkg::GENERAL_CONFIG_REGISTER_ADDR, 16'hA5A5, 3'h3, 4, 1'b0);
    chk_code(status_pkg::RSP_OK);
    do_reset;
    // offered on the release edge, before the defaults are loaded
    op(1'b0, 8'h10, 16'h0000, 3'h3, 0, 1'b0);
    chk(pick(rsp), resp(status_pkg::RSP_XE, 16'h0000), "init");
    rd_status({12'h000, status_pkg::ERR_INIT});
    repeat (3) @(posedge clk);
    chk({10'h000, nv_default0}, 26'hA5A5, "nv load");
    $display("test nv done");
  endtask
  initial begin
    do_reset;
    t_basic;
    t_errors;
    t_exec;
    t_pending;
    t_ready;
    t_nv;
    print_verdict;
  end
  initial begin
    #8000;
    n_errors++;
    $display("BAD %0t watchdog expired", $time);
    print_verdict;
  end
endmodule
